// >>> hw/jtp_port.sv
`timescale 1ns/100ps
// Function
// - Sixteen-state controller stepped by test clock, steered by mode select.
// - Inputs sampled on rising edges; serial output changes on falling edges.
// - Five states hold while mode select is low.
// - Mode select high for five clocks reaches test-logic reset.
// - Power-on state is test-logic reset.
// - Reset exits to idle; idle does nothing unless an operation pends.
// - Capture-DR parallel-loads the selected data register; address and data shift leave the column path as it was.
// - Capture-IR loads 01 into the instruction path; update without shift selects identification read.
// - Capture goes to shift or exit1; DR and IR branches alike.
// - Shift leads to exit1, then update or pause; update goes to idle or select-DR.
// - Pause holds the path; exit2 returns to shift or update.
// - Program, erase, verify, lock and signature program start on the second rising edge spent in idle.
// - All other instructions act in the update state.
// - Held instruction picks the data register for capture, shift, update.
// - Thirty-two bit signature store, programmable and readable.
// - Lock bit blocks configuration readout; erase or reset clears it.
// - Four wire link following boundary-scan protocol.
// - Eight-bit instruction; all ones, extest and sample use bypass.
// - Identification instruction connects 32-bit ID register.
// - Outputs-off, address and data shift instructions disable outputs.
// - Column program at second idle edge, only in program mode.
module jtp_port
  import jtp_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT, // Arbitrary identification value
  parameter int              CFG_W    = 81         // Column data register width
) (
  input  wire logic               core_clk,       // System clock
  input  wire logic               reset,          // Asynchronous reset
  input  wire logic               tck,            // Link test clock
  input  wire logic               tms,            // Mode select
  input  wire logic               tdi,            // Serial data in
  output logic                    tdo,            // Serial data out
  output logic                    tdo_oe,         // Serial out enable
  input  wire logic [CFG_W-1:0]   cfg_rd_data,    // Column read from storage
  output logic      [CFG_W-1:0]   cfg_wr_data,    // Column data to program
  output jtp_op_s                 op_pulse,       // One-cycle operation pulses
  output jtp_status_s             status          // Synchronised status
);
  import jtp_pkg::*;

  initial begin
    if (CFG_W < 2) $error("jtp_port CFG_W too small");
  end

  typedef struct packed {
    jtp_state_e       st;
    logic [IR_W-1:0]  ir_sh;
    logic [IR_W-1:0]  ir;
    logic             ir_loaded;
    logic [SIG_W-1:0] dr_sh;
    logic [CFG_W-1:0] cfg_sh;
    logic [CFG_W-1:0] cfg_data;
    logic             byp;
    logic [SIG_W-1:0] sig;
    logic             lock;
    logic             prog_mode;
    logic             pend;
    logic [1:0]       idle_cnt;
    logic             tg_prog;
    logic             tg_erase;
    logic             tg_verify;
  } jtp_link_s;

  jtp_link_s l;
  jtp_link_s next_l;

  function automatic jtp_state_e step(input jtp_state_e s, input logic m);
    case (s)
      ST_RESET:    step = m ? ST_RESET : ST_IDLE;
      ST_IDLE:     step = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   step = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: step = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: step = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: step = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   step = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   step = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: step = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: step = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: step = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   step = m ? ST_SEL_DR : ST_IDLE;
      default:     step = ST_RESET;
    endcase
  endfunction

  // Bypass covers all-ones, extest, sample and any unknown code
  function automatic logic is_bypass(input logic [IR_W-1:0] i);
    is_bypass = !(i == INSTR_IDREAD || i == INSTR_SIG_READ || i == INSTR_SIG_PROGRAM
                  || i == INSTR_ADDR_SHIFT || i == INSTR_DATA_SHIFT
                  || i == INSTR_VERIFY);
  endfunction

  function automatic logic is_cfg(input logic [IR_W-1:0] i);
    is_cfg = (i == INSTR_ADDR_SHIFT || i == INSTR_DATA_SHIFT || i == INSTR_VERIFY);
  endfunction

  function automatic logic is_deferred(input logic [IR_W-1:0] i);
    is_deferred = (i == INSTR_COL_PROGRAM || i == INSTR_BULK_ERASE
                   || i == INSTR_VERIFY || i == INSTR_LOCK_PROG
                   || i == INSTR_SIG_PROGRAM);
  endfunction

  logic serial_bit;
  logic shifting;
  logic [IR_W-1:0]  upd_ir;
  logic [CFG_W-1:0] rd_sync;

  // An instruction scan that never reached shift falls back to identification read
  assign upd_ir = l.ir_loaded ? l.ir_sh : INSTR_IDREAD;

  // Column read data comes from another domain; stale by up to two link clocks
  jtp_sync #(.W(CFG_W)) u_rd_sync (
    .clk (tck),
    .rst (reset),
    .d   (cfg_rd_data),
    .q   (rd_sync)
  );

  always_comb begin
    next_l    = l;
    next_l.st = step(l.st, tms);
    case (l.st)
      ST_RESET: begin
        next_l.ir   = INSTR_IDREAD;
        next_l.pend = 1'b0;
      end
      ST_CAP_IR: begin
        next_l.ir_sh     = {{(IR_W-2){1'b0}}, IR_CAPTURE_LSB};
        next_l.ir_loaded = 1'b0;
      end
      ST_SHIFT_IR: begin
        next_l.ir_sh     = {tdi, l.ir_sh[IR_W-1:1]};
        next_l.ir_loaded = 1'b1;
      end
      ST_UPD_IR: begin
        next_l.ir   = upd_ir;
        next_l.pend = is_deferred(upd_ir);
        if (upd_ir == INSTR_PROG_EN) begin
          next_l.prog_mode = 1'b1;
        end
        if (upd_ir == INSTR_PROG_DIS) begin
          next_l.prog_mode = 1'b0;
        end
      end
      ST_CAP_DR: begin
        next_l.byp = 1'b0;
        if (l.ir == INSTR_IDREAD) begin
          next_l.dr_sh = ID_VALUE;
        end else if (l.ir == INSTR_SIG_READ || l.ir == INSTR_SIG_PROGRAM) begin
          next_l.dr_sh = l.sig;
        end else if (l.ir == INSTR_VERIFY) begin
          next_l.cfg_sh = l.lock ? '0 : rd_sync;
        end
      end
      ST_SHIFT_DR: begin
        if (is_bypass(l.ir)) begin
          next_l.byp = tdi;
        end else if (is_cfg(l.ir)) begin
          next_l.cfg_sh = {tdi, l.cfg_sh[CFG_W-1:1]};
        end else begin
          next_l.dr_sh = {tdi, l.dr_sh[SIG_W-1:1]};
        end
      end
      ST_UPD_DR: begin
        if (l.ir == INSTR_DATA_SHIFT) begin
          next_l.cfg_data = l.cfg_sh;
        end
      end
      default: begin
      end
    endcase

    // Counts rising edges spent in idle; entry edge is the first
    if (next_l.st == ST_IDLE) begin
      next_l.idle_cnt = (l.st == ST_IDLE && l.idle_cnt != EXEC_EDGE)
                        ? l.idle_cnt + 2'h1 : 2'h1;
    end else begin
      next_l.idle_cnt = '0;
    end

    // Runs only if the host stays in idle; leaving early keeps it pending,
    // so data shifted after the instruction is the data that gets used
    if (l.pend && l.st == ST_IDLE && next_l.st == ST_IDLE
        && l.idle_cnt == EXEC_EDGE - 2'h1) begin
      next_l.pend = 1'b0;
      case (l.ir)
        INSTR_COL_PROGRAM: begin
          if (l.prog_mode) begin
            next_l.tg_prog = ~l.tg_prog;
          end
        end
        INSTR_LOCK_PROG: begin
          if (l.prog_mode) begin
            next_l.lock = 1'b1;
          end
        end
        INSTR_SIG_PROGRAM: begin
          if (l.prog_mode) begin
            next_l.sig = l.dr_sh;
          end
        end
        INSTR_BULK_ERASE: begin
          if (l.prog_mode) begin
            next_l.lock     = 1'b0;
            next_l.sig      = '0;
            next_l.tg_erase = ~l.tg_erase;
          end
        end
        INSTR_VERIFY: begin
          next_l.tg_verify = ~l.tg_verify;
        end
        default: begin
        end
      endcase
    end
  end

  // Nonvolatile cells are modelled as flops cleared by reset and by erase
  always_ff @(posedge tck or posedge reset) begin
    if (reset) begin
      l    <= '0;
      l.st <= ST_RESET;
      l.ir <= INSTR_IDREAD;
    end else begin
      l <= next_l;
    end
  end

  always_comb begin
    case (l.st)
      ST_SHIFT_IR: serial_bit = l.ir_sh[0];
      ST_SHIFT_DR: begin
        if (is_bypass(l.ir)) begin
          serial_bit = l.byp;
        end else if (is_cfg(l.ir)) begin
          serial_bit = l.cfg_sh[0];
        end else begin
          serial_bit = l.dr_sh[0];
        end
      end
      default: serial_bit = 1'b0;
    endcase
  end

  assign shifting = (l.st == ST_SHIFT_DR || l.st == ST_SHIFT_IR);

  jtp_tdo u_tdo (
    .tck      (tck),
    .rst      (reset),
    .bit_in   (serial_bit),
    .shifting (shifting),
    .tdo      (tdo),
    .tdo_oe   (tdo_oe)
  );

  // Core side crossing: levels through two flops, events by toggles
  localparam int XW = SIG_W + 6;
  logic [XW-1:0] x_sync;
  logic          off_lvl;

  assign off_lvl = (l.ir == INSTR_OUTPUTS_OFF || l.ir == INSTR_ADDR_SHIFT
                    || l.ir == INSTR_DATA_SHIFT || l.ir == INSTR_COL_PROGRAM
                    || l.ir == INSTR_VERIFY || l.ir == INSTR_LOCK_PROG);

  jtp_sync #(.W(XW)) u_sync (
    .clk (core_clk),
    .rst (reset),
    .d   ({l.sig, l.lock, l.prog_mode, off_lvl, l.tg_prog, l.tg_erase, l.tg_verify}),
    .q   (x_sync)
  );

  typedef struct packed {
    jtp_status_s      st;
    logic [2:0]       tg;
    jtp_op_s          op;
    logic [CFG_W-1:0] wr;
  } jtp_core_s;

  jtp_core_s c;
  jtp_core_s next_c;

  // Column data is stable long before the program toggle arrives
  always_comb begin
    next_c        = c;
    next_c.st     = x_sync[XW-1:3];
    next_c.tg     = x_sync[2:0];
    next_c.op     = jtp_op_s'(x_sync[2:0] ^ c.tg);
    if (x_sync[2] != c.tg[2]) begin
      next_c.wr = l.cfg_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign op_pulse    = c.op;
  assign status      = c.st;
  assign cfg_wr_data = c.wr;
endmodule

// >>> hw/jtp_pkg.sv
package jtp_pkg;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtp_state_e;

  localparam int IR_W  = 8;
  localparam int SIG_W = 32;
  localparam int ID_W  = 32;

  localparam logic [IR_W-1:0] INSTR_BYPASS      = 8'hff;
  localparam logic [IR_W-1:0] INSTR_EXTEST      = 8'h00;
  localparam logic [IR_W-1:0] INSTR_SAMPLE      = 8'h1c;
  localparam logic [IR_W-1:0] INSTR_IDREAD      = 8'h16;
  localparam logic [IR_W-1:0] INSTR_OUTPUTS_OFF = 8'h18;
  localparam logic [IR_W-1:0] INSTR_ADDR_SHIFT  = 8'h01;
  localparam logic [IR_W-1:0] INSTR_DATA_SHIFT  = 8'h02;
  localparam logic [IR_W-1:0] INSTR_BULK_ERASE  = 8'h03;
  localparam logic [IR_W-1:0] INSTR_COL_PROGRAM = 8'h07;
  localparam logic [IR_W-1:0] INSTR_LOCK_PROG   = 8'h09;
  localparam logic [IR_W-1:0] INSTR_VERIFY      = 8'h0a;
  localparam logic [IR_W-1:0] INSTR_PROG_EN     = 8'h15;
  localparam logic [IR_W-1:0] INSTR_PROG_DIS    = 8'h1e;
  localparam logic [IR_W-1:0] INSTR_SIG_PROGRAM = 8'h1a;
  localparam logic [IR_W-1:0] INSTR_SIG_READ    = 8'h17;

  // Arbitrary neutral identification value
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_0001;
  // Low two bits of the captured instruction path
  localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
  // Operation fires on this idle edge count
  localparam logic [1:0] EXEC_EDGE = 2'h2;

  // Status presented to the core clock domain
  typedef struct packed {
    logic [SIG_W-1:0] sig;
    logic             lock;
    logic             prog_mode;
    logic             outputs_off;
  } jtp_status_s;

  // Operation events raised on the link side
  typedef struct packed {
    logic col_program;
    logic erase;
    logic verify;
  } jtp_op_s;

endpackage

// >>> hw/jtp_sync.sv
`timescale 1ns/100ps
module jtp_sync
  import jtp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,   // Destination clock
  input  wire logic         rst,   // Asynchronous reset
  input  wire logic [W-1:0] d,     // Async level
  output logic      [W-1:0] q      // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jtp_sync_s;

  jtp_sync_s r;
  jtp_sync_s next_r;

  initial begin
    if (W < 1) $error("jtp_sync width");
  end

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule

// >>> hw/jtp_tdo.sv
`timescale 1ns/100ps
module jtp_tdo
  import jtp_pkg::*;
(
  input  wire logic tck,       // Link clock
  input  wire logic rst,       // Asynchronous reset
  input  wire logic bit_in,    // Serial bit at the path end
  input  wire logic shifting,  // Controller is in a shift state
  output logic      tdo,       // Serial output
  output logic      tdo_oe     // Output enable
);
  typedef struct packed {
    logic d;
    logic oe;
  } jtp_tdo_s;

  jtp_tdo_s r;
  jtp_tdo_s next_r;

  always_comb begin
    next_r    = r;
    next_r.d  = bit_in;
    next_r.oe = shifting;
  end

  // Falling edge launch gives the host a half period of setup
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tdo    = r.d;
  assign tdo_oe = r.oe;
endmodule

// >>> tb/jtp_port_sva.sv
`timescale 1ns/100ps
module jtp_port_sva
  import jtp_pkg::*;
#(
  parameter int CFG_W = 81
) (
  input wire logic             core_clk,    // Clock
  input wire logic             reset,       // Reset
  input wire logic             tck,         // Link clock
  input wire logic             tms,         // Mode
  input wire logic             tdo,         // Out
  input wire logic             tdo_oe,      // Out enable
  input wire logic [CFG_W-1:0] cfg_wr_data, // Column
  input wire jtp_op_s          op_pulse,    // Ops
  input wire jtp_status_s      status       // Status
);
  // Own copy of the controller, so the enable is judged from the wire alone
  jtp_state_e st;
  function automatic jtp_state_e nxt(jtp_state_e s, logic m);
    case (s)
      ST_RESET: return m ? ST_RESET : ST_IDLE;
      ST_IDLE, ST_UPD_DR, ST_UPD_IR: return m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
      ST_SEL_IR: return m ? ST_RESET : ST_CAP_IR;
      ST_CAP_DR, ST_SHIFT_DR: return m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: return m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: return m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: return m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_CAP_IR, ST_SHIFT_IR: return m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: return m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: return m ? ST_EXIT2_IR : ST_PAUSE_IR;
      default: return m ? ST_UPD_IR : ST_SHIFT_IR;
    endcase
  endfunction
  always_ff @(posedge tck or posedge reset) begin
    if (reset) st <= ST_RESET;
    else st <= nxt(st, tms);
  end
  a_oe_shift: assert property (@(posedge tck) disable iff (reset)
    tdo_oe == (st inside {ST_SHIFT_DR, ST_SHIFT_IR})) else $error("enable off shift");
  a_tdo_quiet: assert property (@(posedge tck) disable iff (reset)
    !tdo_oe |-> !tdo) else $error("tdo set while off");
  a_tdo_fall: assert property (@(posedge core_clk) disable iff (reset)
    tck && $past(tck) |-> $stable(tdo)) else $error("tdo moved, clock high");
  a_pulse_one: assert property (@(posedge core_clk) disable iff (reset)
    op_pulse != '0 |=> op_pulse == '0) else $error("op pulse too long");
  a_pulse_idle: assert property (@(posedge core_clk) disable iff (reset)
    op_pulse != '0 |-> st == ST_IDLE) else $error("op outside idle");
  a_prog_gate: assert property (@(posedge core_clk) disable iff (reset)
    op_pulse.col_program || op_pulse.erase |-> status.prog_mode)
    else $error("op without program mode");
  a_erase_clear: assert property (@(posedge core_clk) disable iff (reset)
    op_pulse.erase |-> ##[0:8] !status.lock && status.sig == '0)
    else $error("erase left lock set");
  a_cfg_hold: assert property (@(posedge core_clk) disable iff (reset)
    !$stable(cfg_wr_data) |-> op_pulse.col_program || $past(op_pulse.col_program))
    else $error("column moved alone");
endmodule
bind jtp_port jtp_port_sva #(.CFG_W(CFG_W)) u_sva (
  .core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
  .cfg_wr_data(cfg_wr_data), .op_pulse(op_pulse), .status(status));

// >>> tb/jtp_host.sv
`timescale 1ns/100ps
module jtp_host (
  output logic      tck,   // Link clock
  output logic      tms,   // Mode
  output logic      tdi,   // To device
  input  wire logic tdo,   // From device
  input  wire logic tdo_oe // Device drives
);
  logic last = 1'b0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Clock runs only inside a step, so it stands still between frames
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    // A released line must not pass for the last bit
    o = tdo_oe ? tdo : ~last;
    last = o;
    #80 tck = 1'b0;
  endtask
  task automatic walk(input int n, input logic [15:0] p);
    logic b;
    for (int i = 0; i < n; i++) step(p[i], 1'b0, b);
  endtask
  task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  task automatic ir(input logic [7:0] code, output logic [7:0] cap);
    logic [127:0] q;
    walk(4, 16'h3);
    scan(8, {120'h0, code}, q);
    cap = q[7:0];
    walk(2, 16'h1);
  endtask
  task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    walk(3, 16'h1);
    scan(n, din, dout);
    walk(2, 16'h1);
  endtask
endmodule

// >>> tb/jtp_port_bench.sv
`timescale 1ns/100ps
module jtp_port_bench;
  import jtp_pkg::*;
  localparam int            CW = 81;
  localparam logic [CW-1:0] RD = 81'h1_2345_6789_abcd_ef01_2345;
  localparam logic [CW-1:0] WR = 81'h0_dead_beef_0bad_cafe_1357;
  localparam logic [31:0]   SG = 32'h5a3c_e187;
  localparam logic [31:0]   IDV = 32'hc3a5_0f96; // Arbitrary identification value
  logic          core_clk, reset, tck, tms, tdi, tdo, tdo_oe;
  logic [CW-1:0] cfg_rd_data, cfg_wr_data;
  jtp_op_s       op_pulse;
  jtp_status_s   status;
  logic [127:0]  q;
  logic [7:0]    c;
  int            error_cnt = 0, n_tests = 0, cyc = 0, n_col = 0, n_era = 0, n_ver = 0, e;

  jtp_port #(.ID_VALUE(IDV), .CFG_W(CW)) DUT (
    .core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cfg_rd_data(cfg_rd_data),
    .cfg_wr_data(cfg_wr_data), .op_pulse(op_pulse), .status(status));
  jtp_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    n_col += int'(op_pulse.col_program === 1'b1);
    n_era += int'(op_pulse.erase === 1'b1);
    n_ver += int'(op_pulse.verify === 1'b1);
    if (cyc == 60000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic t_power_on;
    host.walk(1, 16'h0);
    host.dr(32, '0, q);
    chk(q, IDV);
  endtask
  task automatic t_bypass;
    logic [7:0] codes [3];
    codes = '{INSTR_BYPASS, INSTR_EXTEST, INSTR_SAMPLE};
    foreach (codes[i]) begin
      host.ir(codes[i], c);
      chk(c, 128'h01);
      host.dr(8, 128'ha5, q);
      chk(q, 128'h4a);
    end
  endtask
  task automatic t_reset_paths;
    host.ir(INSTR_BYPASS, c);
    host.walk(9, 16'h0f9); // Into shift, five highs, then idle
    host.dr(32, '0, q);
    chk(q, IDV);
    host.ir(INSTR_BYPASS, c);
    host.walk(6, 16'h1b); // Capture straight to exit and update
    host.dr(32, '0, q);
    chk(q, IDV);
  endtask
  task automatic t_pause;
    logic [127:0] lo;
    host.ir(INSTR_IDREAD, c);
    host.walk(3, 16'h1);
    host.scan(16, '0, lo);
    host.walk(5, 16'h08); // Three clocks in pause, then back to shift
    host.scan(16, '0, q);
    host.walk(2, 16'h1);
    chk({q[111:0], lo[15:0]}, IDV);
    chk(status.outputs_off, 1'b0);
  endtask
  task automatic t_program;
    host.ir(INSTR_PROG_DIS, c);
    e = n_col;
    host.ir(INSTR_COL_PROGRAM, c);
    host.walk(2, 16'h0);
    chk(n_col, e);
    host.ir(INSTR_PROG_EN, c);
    host.ir(INSTR_ADDR_SHIFT, c);
    chk(status.outputs_off, 1'b1);
    host.ir(INSTR_DATA_SHIFT, c);
    host.dr(CW, WR, q);
    e = n_col;
    host.ir(INSTR_COL_PROGRAM, c);
    chk(n_col, e);
    host.walk(1, 16'h0);
    chk(n_col, e + 1);
    chk(cfg_wr_data, WR);
  endtask
  task automatic t_sig;
    host.ir(INSTR_SIG_PROGRAM, c);
    host.dr(32, SG, q);
    host.walk(1, 16'h0);
    chk(status.sig, SG);
    host.ir(INSTR_SIG_READ, c);
    host.dr(32, '0, q);
    chk(q, SG);
  endtask
  task automatic t_lock;
    e = n_ver;
    host.ir(INSTR_VERIFY, c);
    host.dr(CW, '0, q);
    chk(q, RD);
    host.walk(1, 16'h0);
    chk(n_ver, e + 1);
    host.ir(INSTR_LOCK_PROG, c);
    host.walk(1, 16'h0);
    chk(status.lock, 1'b1);
    host.ir(INSTR_VERIFY, c);
    host.dr(CW, '0, q);
    chk(q, 128'h0);
    e = n_era;
    host.ir(INSTR_BULK_ERASE, c);
    host.walk(1, 16'h0);
    chk(n_era, e + 1);
    chk({status.lock, status.sig}, 128'h0);
  endtask

  initial begin
    reset = 1'b1;
    cfg_rd_data = RD;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    #33.3; // Keeps the link clock out of phase with the core clock
    t_power_on();
    t_bypass();
    t_reset_paths();
    t_pause();
    t_program();
    t_sig();
    t_lock();
    complete_run();
  end
endmodule
